// ==== sim/pssb_chk.sv ====
`timescale 1ns/10ps
module pssb_chk
  import pssb_pkg::*;
#(
  parameter int LANES = 1
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [CMD_OUT_W-1:0] o_common_commands_out,
  input wire logic [LANES*LANE_BUS_W-1:0] i_pipe_rx_buses,
  input wire logic [LANES*LANE_BUS_W-1:0] o_pipe_tx_buses,
  input wire logic [LANES*DATA_W-1:0] i_lane_transmit_data,
  input wire logic [LANES*SYNC_W-1:0] i_lane_transmit_sync_header,
  input wire logic [LANES*DATA_W-1:0] o_lane_receive_data,
  input wire logic [LANES*SYNC_W-1:0] o_lane_receive_sync_header
);
  // ****
  // Lane 0 and command bus
  // ****
  logic wr_dp;
  wire logic p;
  wire logic [1:0] r;
  assign p = o_common_commands_out[CMD_PCLK];
  assign r = o_common_commands_out[2:1];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      wr_dp <= 1'b0;
    else
      wr_dp <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
  // Rate history spares the half period in flight when the rate moves
  sequence s_slow;
    $changed(p) && r == 2'h0 && $past(r) == 2'h0 ##1 r == 2'h0;
  endsequence
  AST_SLOW_HOLD: assert property (s_slow |-> $stable(p))
    else $error("gen1 clock early");
  AST_SLOW_TOG: assert property (s_slow ##1 r == 2'h0 |-> $changed(p))
    else $error("gen1 clock late");
  AST_FAST: assert property (
    r != 2'h0 && $past(r) != 2'h0 && $past(r, 2) != 2'h0 |-> $changed(p))
    else $error("fast clock stalled");
  AST_SPARE: assert property (o_common_commands_out[16:10] == 7'h00)
    else $error("spare command bits set");
  AST_CMD_HOLD: assert property (
    $changed(o_common_commands_out[9:1]) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("command moved without write");
  AST_TX_DATA: assert property (
    $past(i_resetn) |-> o_pipe_tx_buses[31:0] == $past(i_lane_transmit_data[31:0]))
    else $error("tx data wrong");
  AST_TX_SYNC: assert property (
    $past(i_resetn) |-> o_pipe_tx_buses[38:37] == $past(i_lane_transmit_sync_header[1:0]))
    else $error("tx sync wrong");
  AST_TX_SPARE: assert property (o_pipe_tx_buses[83:42] == 42'h0)
    else $error("tx spare set");
  AST_RX_DATA: assert property (
    $past(i_resetn) && $past(i_resetn, 2)
    |-> o_lane_receive_data[31:0] == $past(i_pipe_rx_buses[31:0], 2))
    else $error("rx data wrong");
  AST_RX_SYNC: assert property (
    $past(i_resetn) && $past(i_resetn, 2)
    |-> o_lane_receive_sync_header[1:0] == $past(i_pipe_rx_buses[38:37], 2))
    else $error("rx sync wrong");
endmodule

bind pssb_top pssb_chk #(.LANES(LANES)) u_chk (
  .i_clk, .i_resetn, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
  .o_common_commands_out, .i_pipe_rx_buses, .o_pipe_tx_buses,
  .i_lane_transmit_data, .i_lane_transmit_sync_header,
  .o_lane_receive_data, .o_lane_receive_sync_header
);

// ==== sim/pssb_partner.sv ====
`timescale 1ns/10ps
module pssb_partner
  import pssb_pkg::*;
(
  input wire logic [CMD_OUT_W-1:0] i_cmd,
  input wire logic [LANE_BUS_W-1:0] i_tx_bus,
  output logic [LANE_BUS_W-1:0] o_rx_bus
);
  // ****
  // Loopback lane partner
  // ****
  // Command bits 16:10 are never looked at
  initial o_rx_bus = '0;
  always @(posedge i_cmd[CMD_PCLK])
  begin
    o_rx_bus[38:0] <= i_tx_bus[38:0];
    // Unused bits churn so nothing can lean on them
    o_rx_bus[83:39] <= ~o_rx_bus[83:39];
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import pssb_pkg::*;
;
  logic clk, rstn, hsel, hwrite, rdy, li, lv, lb, ri, rv, rb, hresp;
  logic [31:0] haddr, hwdata, hrdata, ld, rd, r;
  logic [1:0] htrans, lk, ls, rk, rs;
  logic [CMD_IN_W-1:0] cmd_in;
  logic [CMD_OUT_W-1:0] cmd;
  logic [LANE_BUS_W-1:0] rxb, txb;
  // Last word uses the undefined rate code, which must still run the fast clock
  logic [31:0] wv [4] = '{32'h00000154, 32'h000000A9, 32'h00000112, 32'h00000083};
  int errors, cmp_count, cyc, n;

  pssb_top #(.LANES(1)) dut (
    .i_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp),
    .i_common_commands_in(cmd_in), .o_common_commands_out(cmd),
    .i_pipe_rx_buses(rxb), .o_pipe_tx_buses(txb),
    .i_lane_transmit_data(ld), .i_lane_transmit_control_char(lk),
    .i_lane_transmit_idle(li), .i_lane_transmit_valid(lv),
    .i_lane_transmit_block_start(lb), .i_lane_transmit_sync_header(ls),
    .o_lane_receive_data(rd), .o_lane_receive_control_char(rk),
    .o_lane_receive_idle(ri), .o_lane_receive_valid(rv),
    .o_lane_receive_block_start(rb), .o_lane_receive_sync_header(rs)
  );
  pssb_partner u_far (.i_cmd(cmd), .i_tx_bus(txb), .o_rx_bus(rxb));

  // ****
  // Clock, watchdog, helpers
  // ****
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string s, logic [83:0] seen, logic [83:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Entered just after a rising edge; hready is this slave's own output
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] o);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    o = hrdata;
  endtask
  task automatic per(output int c);
    c = 0;
    while (cmd[0] !== 1'b0) @(posedge clk);
    while (cmd[0] !== 1'b1) @(posedge clk);
    while (cmd[0] !== 1'b0) @(posedge clk) c++;
    while (cmd[0] !== 1'b1) @(posedge clk) c++;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_rate;
    logic [31:0] c0;
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, ADDR_CMD, wv[i], r);
      repeat (2) @(posedge clk);
      chk("cmd", cmd[9:1], wv[i][8:0]);
      chk("spare", cmd[16:10], 7'h00);
      ahb(1'b0, ADDR_CMD, 32'h0, r);
      chk("cmd rd", r, wv[i]);
      cmd_in <= ~cmd_in;
      repeat (4) @(posedge clk);
      per(n);
      chk("period", n, 2 * (i == 0 ? PCLK_GEN1_HALF : PCLK_GEN23_HALF));
      // Two reads one idle cycle apart span exactly four clock cycles
      ahb(1'b0, ADDR_PCNT, 32'h0, c0);
      @(posedge clk);
      ahb(1'b0, ADDR_PCNT, 32'h0, r);
      chk("pclk count", r - c0, 4 / (2 * (i == 0 ? PCLK_GEN1_HALF : PCLK_GEN23_HALF)));
      chk("cmd hold", cmd[9:1], wv[i][8:0]);
    end
  endtask
  task automatic t_lane;
    logic [38:0] v;
    logic [31:0] lw;
    for (int j = 0; j < 2; j++)
    begin
      v = j ? ~39'h2AA5C30F96 : 39'h2AA5C30F96;
      lw = j ? 32'h00000100 : 32'h00000201;
      ahb(1'b1, ADDR_LANE, lw, r);
      {ls, lb, lv, li, lk, ld} <= v;
      repeat (3) @(posedge clk);
      chk("tx", txb, {42'h0, lw[9:8], lw[0], v});
      n = 0;
      while (rd !== v[31:0] && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      chk("rx", {rs, rb, rv, ri, rk, rd}, v);
      ahb(1'b0, ADDR_STAT, 32'h0, r);
      chk("stat", r[15:0], {7'h0, v[35], 7'h0, v[34]});
    end
  endtask

  initial
  begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cmd_in = '0;
    {ls, lb, lv, li, lk, ld} = 39'h0;
    repeat (6) @(posedge clk);
    chk("rst cmd", cmd, 17'h00100);
    chk("rst tx", txb, 84'h0);
    rstn <= 1'b1;
    @(posedge clk);
    ahb(1'b0, ADDR_CMD, 32'h0, r);
    chk("cmd rst", r, CMD_RST);
    ahb(1'b0, ADDR_LANE, 32'h0, r);
    chk("lane rst", r, LANE_RST);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", r, 32'h0);
    chk("hresp", hresp, 1'b0);
    t_rate;
    t_lane;
    end_sim;
  end
endmodule

// ==== src/pssb_lane.sv ====
`timescale 1ns/10ps
module pssb_lane
  import pssb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  pssb_lane_if.lane lif,
  input wire logic [LANE_BUS_W-1:0] i_rx_bus,
  output logic [LANE_BUS_W-1:0] o_tx_bus
);

  logic [LANE_BUS_W-1:0] rx_meta;
  logic [LANE_BUS_W-1:0] rx_hold;
  logic [LANE_BUS_W-1:0] next_tx;

  // Pins come from the partner, so two stages before any use
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rx_meta <= '0;
      rx_hold <= '0;
      o_tx_bus <= '0;
    end
    else
    begin
      rx_meta <= i_rx_bus;
      rx_hold <= rx_meta;
      o_tx_bus <= next_tx;
    end
  end

  // Bits 83-39 of the receive bus are never read
  assign lif.rx_data = rx_hold[LN_DATA_LO +: DATA_W];
  assign lif.rx_k = rx_hold[LN_K_LO +: K_W];
  assign lif.rx_idle = rx_hold[LN_IDLE];
  assign lif.rx_valid = rx_hold[LN_VALID];
  assign lif.rx_blk = rx_hold[LN_BLK];
  assign lif.rx_sync = rx_hold[LN_SYNC_LO +: SYNC_W];

  assign next_tx = {
    (LANE_BUS_W - LN_SPARE_LO)'(0),
    lif.pwr,
    lif.pol,
    lif.tx_sync,
    lif.tx_blk,
    lif.tx_valid,
    lif.tx_idle,
    lif.tx_k,
    lif.tx_data
  };

endmodule

// ==== src/pssb_lane_if.sv ====
`timescale 1ns/10ps
interface pssb_lane_if;
  import pssb_pkg::*;
  logic [DATA_W-1:0] tx_data;
  logic [K_W-1:0] tx_k;
  logic tx_idle;
  logic tx_valid;
  logic tx_blk;
  logic [SYNC_W-1:0] tx_sync;
  logic pol;
  logic [PWR_W-1:0] pwr;
  logic [DATA_W-1:0] rx_data;
  logic [K_W-1:0] rx_k;
  logic rx_idle;
  logic rx_valid;
  logic rx_blk;
  logic [SYNC_W-1:0] rx_sync;
  modport lane (input tx_data, tx_k, tx_idle, tx_valid, tx_blk, tx_sync, pol, pwr,
                output rx_data, rx_k, rx_idle, rx_valid, rx_blk, rx_sync);
  modport core (output tx_data, tx_k, tx_idle, tx_valid, tx_blk, tx_sync, pol, pwr,
                input rx_data, rx_k, rx_idle, rx_valid, rx_blk, rx_sync);
endinterface

// ==== src/pssb_pclk_div.sv ====
`timescale 1ns/10ps
module pssb_pclk_div
  import pssb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_gen1,
  output logic o_pclk,
  output logic o_rise
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  wire [3:0] half_m1 = i_gen1 ? 4'(PCLK_GEN1_HALF - 1) : 4'(PCLK_GEN23_HALF - 1);
  // Rate change applies at once to the half period in flight, which can end short
  wire tick = (cnt >= half_m1);

  assign next_cnt = tick ? 4'h0 : cnt + 4'h1;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt <= 4'h0;
      o_pclk <= 1'b0;
      o_rise <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      if (tick)
        o_pclk <= ~o_pclk;
      o_rise <= tick & ~o_pclk;
    end
  end

endmodule

// ==== src/pssb_pkg.sv ====
package pssb_pkg;

  // ****************************************
  // Bus widths
  // ****************************************
  localparam int CMD_IN_W = 26;
  localparam int CMD_OUT_W = 17;
  localparam int LANE_BUS_W = 84;
  localparam int MAX_LANES = 8;
  localparam int DATA_W = 32;
  localparam int K_W = 2;
  localparam int SYNC_W = 2;
  localparam int PWR_W = 2;
  localparam int RATE_W = 2;
  localparam int MARGIN_W = 3;

  // ****************************************
  // Outgoing command bit positions
  // ****************************************
  localparam int CMD_PCLK = 0;
  localparam int CMD_RATE_LO = 1;
  localparam int CMD_DET = 3;
  localparam int CMD_MARGIN_LO = 4;
  localparam int CMD_SWING = 7;
  localparam int CMD_TXRST = 8;
  localparam int CMD_DEEMPH = 9;
  localparam int CMD_SPARE_LO = 10;

  // ****************************************
  // Lane bus field positions
  // ****************************************
  localparam int LN_DATA_LO = 0;
  localparam int LN_K_LO = 32;
  localparam int LN_IDLE = 34;
  localparam int LN_VALID = 35;
  localparam int LN_BLK = 36;
  localparam int LN_SYNC_LO = 37;
  localparam int LN_POL = 39;
  localparam int LN_PWR_LO = 40;
  localparam int LN_SPARE_LO = 42;

  typedef enum logic [RATE_W-1:0] {
    RATE_GEN1 = 2'h0,
    RATE_GEN2 = 2'h1,
    RATE_GEN3 = 2'h2
  } pssb_rate_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LANE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PCNT = 8'h0C;
  localparam int REG_RATE_LO = 0;
  localparam int REG_DET = 2;
  localparam int REG_MARGIN_LO = 3;
  localparam int REG_SWING = 6;
  localparam int REG_TXRST = 7;
  localparam int REG_DEEMPH = 8;
  localparam int REG_POL_LO = 0;
  localparam int REG_PWR_LO = 8;
  localparam int STAT_IDLE_LO = 0;
  localparam int STAT_VALID_LO = 8;
  localparam int STAT_PCLK = 16;
  localparam logic [31:0] CMD_RST = 32'h00000080;
  localparam logic [31:0] LANE_RST = 32'h00000000;

  // ****************************************
  // Interface clock rates
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int PCLK_GEN1_MHZ = 125;
  localparam int PCLK_GEN23_MHZ = 250;
  localparam int PCLK_GEN23_HALF = 1;
  localparam int PCLK_GEN1_HALF = PCLK_GEN23_HALF * PCLK_GEN23_MHZ / PCLK_GEN1_MHZ;

endpackage

// ==== src/pssb_top.sv ====
// Function
// - Core PHY signals wire straight to the partner's PHY signals, no transceivers.
// - All 26 incoming command bits are ignored.
// - PHY clock goes out on command bit 0.
// - PHY clock runs 125 MHz at first generation, 250 MHz otherwise; the divider gives i_clk/4 and i_clk/2 instead.
// - Rate on command bits 2:1: 00 gen1, 01 gen2, 10 gen3.
// - Receiver-detect request on command bit 3.
// - Margin on command bits 6:4, swing select on bit 7.
// - Transmitter reset on bit 8, de-emphasis select on bit 9.
// - Command bits 16:10 carry nothing.
// - Receive bus: data, control flags, idle, valid, block start, sync header.
// - Transmit bus carries data, flags, idle, valid, start, sync, polarity, power.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module pssb_top
  import pssb_pkg::*;
#(
  parameter int LANES = 1
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [CMD_IN_W-1:0] i_common_commands_in,
  output logic [CMD_OUT_W-1:0] o_common_commands_out,
  input wire logic [LANES*LANE_BUS_W-1:0] i_pipe_rx_buses,
  output logic [LANES*LANE_BUS_W-1:0] o_pipe_tx_buses,
  input wire logic [LANES*DATA_W-1:0] i_lane_transmit_data,
  input wire logic [LANES*K_W-1:0] i_lane_transmit_control_char,
  input wire logic [LANES-1:0] i_lane_transmit_idle,
  input wire logic [LANES-1:0] i_lane_transmit_valid,
  input wire logic [LANES-1:0] i_lane_transmit_block_start,
  input wire logic [LANES*SYNC_W-1:0] i_lane_transmit_sync_header,
  output logic [LANES*DATA_W-1:0] o_lane_receive_data,
  output logic [LANES*K_W-1:0] o_lane_receive_control_char,
  output logic [LANES-1:0] o_lane_receive_idle,
  output logic [LANES-1:0] o_lane_receive_valid,
  output logic [LANES-1:0] o_lane_receive_block_start,
  output logic [LANES*SYNC_W-1:0] o_lane_receive_sync_header
);

  // ****************************************
  // Register state
  // ****************************************
  logic [RATE_W-1:0] link_rate_select;
  logic receiver_detect_request;
  logic [MARGIN_W-1:0] transmit_margin_level;
  logic transmit_swing_select;
  logic transmitter_reset;
  logic transmit_deemphasis_select;
  logic [MAX_LANES-1:0] lane_polarity_invert;
  logic [2*MAX_LANES-1:0] lane_power_state;
  logic [31:0] pclk_count;

  logic pclk;
  logic pclk_rise;
  logic [MAX_LANES-1:0] rx_idle_v;
  logic [MAX_LANES-1:0] rx_valid_v;

  // ****************************************
  // Bus state
  // ****************************************
  logic wr_pend;
  logic rd_pend;
  logic [ADDR_W-1:0] acc_addr;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  wire take = i_hsel & i_htrans[1] & i_hready;
  wire take_wr = take & i_hwrite;
  wire take_rd = take & ~i_hwrite;
  wire [ADDR_W-1:0] take_addr = i_haddr[ADDR_W-1:0];
  wire wr_cmd = wr_pend & hit(acc_addr, ADDR_CMD);
  wire wr_lane = wr_pend & hit(acc_addr, ADDR_LANE);

  wire [31:0] cmd_word = {
    23'h000000,
    transmit_deemphasis_select,
    transmitter_reset,
    transmit_swing_select,
    transmit_margin_level,
    receiver_detect_request,
    link_rate_select
  };
  wire [31:0] lane_word = {8'h00, lane_power_state, lane_polarity_invert};
  wire [31:0] stat_word = {15'h0000, pclk, rx_valid_v, rx_idle_v};

  // Unmapped offsets read as zero
  wire [31:0] rd_word =
    hit(acc_addr, ADDR_CMD) ? cmd_word :
    hit(acc_addr, ADDR_LANE) ? lane_word :
    hit(acc_addr, ADDR_STAT) ? stat_word :
    hit(acc_addr, ADDR_PCNT) ? pclk_count : 32'h00000000;

  // ****************************************
  // Bus slave
  // ****************************************
  // Reads take one wait state so a write just before is already stored
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= '0;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend <= take_wr;
      rd_pend <= take_rd;
      if (take)
        acc_addr <= take_addr;
      o_hreadyout <= ~take_rd;
      if (rd_pend)
        o_hrdata <= rd_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_hresp <= 1'b0;
    else
      o_hresp <= 1'b0;
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      link_rate_select <= CMD_RST[REG_RATE_LO +: RATE_W];
      receiver_detect_request <= CMD_RST[REG_DET];
      transmit_margin_level <= CMD_RST[REG_MARGIN_LO +: MARGIN_W];
      transmit_swing_select <= CMD_RST[REG_SWING];
      transmitter_reset <= CMD_RST[REG_TXRST];
      transmit_deemphasis_select <= CMD_RST[REG_DEEMPH];
    end
    else if (wr_cmd)
    begin
      link_rate_select <= i_hwdata[REG_RATE_LO +: RATE_W];
      receiver_detect_request <= i_hwdata[REG_DET];
      transmit_margin_level <= i_hwdata[REG_MARGIN_LO +: MARGIN_W];
      transmit_swing_select <= i_hwdata[REG_SWING];
      transmitter_reset <= i_hwdata[REG_TXRST];
      transmit_deemphasis_select <= i_hwdata[REG_DEEMPH];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lane_polarity_invert <= LANE_RST[REG_POL_LO +: MAX_LANES];
      lane_power_state <= LANE_RST[REG_PWR_LO +: 2*MAX_LANES];
    end
    else if (wr_lane)
    begin
      lane_polarity_invert <= i_hwdata[REG_POL_LO +: MAX_LANES];
      lane_power_state <= i_hwdata[REG_PWR_LO +: 2*MAX_LANES];
    end
  end

  // ****************************************
  // Interface clock
  // ****************************************
  // Only the first generation runs the slower clock; 2'b11 runs fast
  wire gen1 = (link_rate_select == RATE_GEN1);

  pssb_pclk_div u_div (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_gen1(gen1),
    .o_pclk(pclk),
    .o_rise(pclk_rise)
  );

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      pclk_count <= 32'h00000000;
    else if (pclk_rise)
      pclk_count <= pclk_count + 32'h00000001;
  end

  // ****************************************
  // Outgoing command bus
  // ****************************************
  // Incoming command bits are deliberately left unread
  assign o_common_commands_out = {
    7'h00,
    transmit_deemphasis_select,
    transmitter_reset,
    transmit_swing_select,
    transmit_margin_level,
    receiver_detect_request,
    link_rate_select,
    pclk
  };

  // ****************************************
  // Lanes
  // ****************************************
  // Status bits above the lane count read zero
  generate
    if (LANES < MAX_LANES)
    begin : g_pad
      assign rx_idle_v[MAX_LANES-1:LANES] = '0;
      assign rx_valid_v[MAX_LANES-1:LANES] = '0;
    end
  endgenerate

  genvar l;
  generate
    for (l = 0; l < LANES; l++)
    begin : g_lane
      pssb_lane_if lif ();

      // Core PHY fields pass straight to the partner's pins
      assign lif.tx_data = i_lane_transmit_data[l*DATA_W +: DATA_W];
      assign lif.tx_k = i_lane_transmit_control_char[l*K_W +: K_W];
      assign lif.tx_idle = i_lane_transmit_idle[l];
      assign lif.tx_valid = i_lane_transmit_valid[l];
      assign lif.tx_blk = i_lane_transmit_block_start[l];
      assign lif.tx_sync = i_lane_transmit_sync_header[l*SYNC_W +: SYNC_W];
      assign lif.pol = lane_polarity_invert[l];
      assign lif.pwr = lane_power_state[l*PWR_W +: PWR_W];

      pssb_lane u_lane (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .lif(lif),
        .i_rx_bus(i_pipe_rx_buses[l*LANE_BUS_W +: LANE_BUS_W]),
        .o_tx_bus(o_pipe_tx_buses[l*LANE_BUS_W +: LANE_BUS_W])
      );

      assign o_lane_receive_data[l*DATA_W +: DATA_W] = lif.rx_data;
      assign o_lane_receive_control_char[l*K_W +: K_W] = lif.rx_k;
      assign o_lane_receive_idle[l] = lif.rx_idle;
      assign o_lane_receive_valid[l] = lif.rx_valid;
      assign o_lane_receive_block_start[l] = lif.rx_blk;
      assign o_lane_receive_sync_header[l*SYNC_W +: SYNC_W] = lif.rx_sync;
      assign rx_idle_v[l] = lif.rx_idle;
      assign rx_valid_v[l] = lif.rx_valid;
    end
  endgenerate

endmodule
